/* core/vdc_voice_dac_ctrl.sv */
/*
 * Register-side control of a 16-bit voice converter: code registers with a
 * low-byte shadow, enable bit, and a conversion-start strobe.
 * Assumes an AXI4-Lite master on sys_clk_in and an analog stage that takes
 * the code on the start pulse.
 * The code and the start strobe leave on the same edge, so the analog stage
 * may latch on the strobe alone.
 * Settling after enable is not timed here; software keeps that interval.
 * A write to a code or control register with byte strobe 0 low is answered OKAY and changes nothing.
 * Inputs other than arst_n_in are synchronous to sys_clk_in; clk_en_in low freezes every flop.
 */
// Notes on behaviour
// - The committed sixteen-bit code built from two bytes drives the analog stage.
// - The high code register holds bits 15 to 8, fully read/write, reset zero.
// - The low code register holds bits 7 to 0, reads the committed byte, writes go to the shadow, reset zero.
// - A low-byte write lands only in the shadow buffer.
// - A high-byte write copies the shadow into the committed low byte at once.
// - Each high-byte write with byte strobe 0 set loads the whole code and starts a conversion.
// - Control bit 0 enables the converter, reset zero.
// - Control bits 7 to 1 ignore writes and read zero.
`timescale 1ns/100ps
module vdc_voice_dac_ctrl (
	input wire logic sys_clk_in, // system clock, 250 MHz
	input wire logic arst_n_in, // async reset, active low
	input wire logic clk_en_in, // freezes all state while low
	input wire logic [31:0] s_axi_awaddr_in, // write address
	input wire logic s_axi_awvalid_in, // write address valid
	output logic s_axi_awready_out, // write address ready
	input wire logic [31:0] s_axi_wdata_in, // write data
	input wire logic [3:0] s_axi_wstrb_in, // write byte strobes
	input wire logic s_axi_wvalid_in, // write data valid
	output logic s_axi_wready_out, // write data ready
	output logic [1:0] s_axi_bresp_out, // write response
	output logic s_axi_bvalid_out, // write response valid
	input wire logic s_axi_bready_in, // write response ready
	input wire logic [31:0] s_axi_araddr_in, // read address
	input wire logic s_axi_arvalid_in, // read address valid
	output logic s_axi_arready_out, // read address ready
	output logic [31:0] s_axi_rdata_out, // read data
	output logic [1:0] s_axi_rresp_out, // read response
	output logic s_axi_rvalid_out, // read data valid
	input wire logic s_axi_rready_in, // read data ready
	output logic [15:0] dac_code_out, // committed code to analog stage
	output logic dac_start_out, // one-cycle conversion start
	output logic dac_enable_out // powers the analog stage
);
	// ********************************************************
	// write channel capture
	// ********************************************************
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0;
	logic [7:0] code_high;
	logic [7:0] code_low;
	logic [7:0] shadow;
	logic enable;

	wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
	wire w_take = s_axi_wvalid_in && s_axi_wready_out;
	wire do_write = aw_held && w_held && !s_axi_bvalid_out;
	wire wr_high = do_write && aw_addr == vdc_pkg::OFF_CODE_HIGH;
	wire wr_low = do_write && aw_addr == vdc_pkg::OFF_CODE_LOW;
	wire wr_ctrl = do_write && aw_addr == vdc_pkg::OFF_CONTROL;
	wire wr_ok = wr_high || wr_low || wr_ctrl;
	// byte lane 0 carries every register; other lanes are don't-care
	wire upd_high = wr_high && w_lane0;
	wire upd_low = wr_low && w_lane0;
	wire upd_ctrl = wr_ctrl && w_lane0;

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= vdc_pkg::RESP_OKAY;
		end else if (clk_en_in) begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_in[3:0];
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata_in[7:0];
				w_lane0 <= s_axi_wstrb_in[0];
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= wr_ok ? vdc_pkg::RESP_OKAY :
					vdc_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// ready is registered so a held channel refuses a second beat
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
		end else if (clk_en_in) begin
			s_axi_awready_out <= !aw_held && !aw_take && !do_write;
			s_axi_wready_out <= !w_held && !w_take && !do_write;
		end
	end

	// ********************************************************
	// code and control registers
	// ********************************************************
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			code_high <= vdc_pkg::CODE_RESET;
			code_low <= vdc_pkg::CODE_RESET;
			shadow <= vdc_pkg::CODE_RESET;
			enable <= vdc_pkg::ENABLE_RESET;
		end else if (clk_en_in) begin
			if (upd_low)
				shadow <= w_byte;
			if (upd_high) begin
				code_high <= w_byte;
				code_low <= shadow;
			end
			if (upd_ctrl)
				enable <= w_byte[vdc_pkg::ENABLE_BIT];
		end
	end

	// ********************************************************
	// converter outputs
	// ********************************************************
	// the code is built from the beat itself so that it leaves on the
	// same edge as the start strobe; the registers settle on that edge too
	wire [15:0] next_dac_code = upd_high ? {w_byte, shadow} :
		{code_high, code_low};

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dac_code_out <= {vdc_pkg::CODE_RESET, vdc_pkg::CODE_RESET};
			dac_start_out <= 1'b0;
			dac_enable_out <= vdc_pkg::ENABLE_RESET;
		end else if (clk_en_in) begin
			dac_code_out <= next_dac_code;
			dac_start_out <= upd_high;
			dac_enable_out <= enable;
		end
	end

	// ********************************************************
	// read channel
	// ********************************************************
	wire [3:0] rd_addr = s_axi_araddr_in[3:0];
	wire rd_take = s_axi_arvalid_in && s_axi_arready_out;
	wire sel_high = rd_addr == vdc_pkg::OFF_CODE_HIGH;
	wire sel_low = rd_addr == vdc_pkg::OFF_CODE_LOW;
	wire sel_ctrl = rd_addr == vdc_pkg::OFF_CONTROL;
	wire sel_shadow = rd_addr == vdc_pkg::OFF_SHADOW;
	wire rd_known = sel_high || sel_low || sel_ctrl || sel_shadow;
	wire [7:0] ctrl_byte;

	// only the enable bit is backed by a flop; the rest read zero
	for (genvar b = 0; b < 8; b++) begin : g_ctrl_bit
		if (b == vdc_pkg::ENABLE_BIT) begin : g_enable
			assign ctrl_byte[b] = enable;
		end else begin : g_unused
			assign ctrl_byte[b] = 1'b0;
		end
	end

	// low reads show the committed byte; the shadow has its own view
	wire [7:0] rd_byte = sel_high ? code_high :
		sel_low ? code_low :
		sel_ctrl ? ctrl_byte :
		sel_shadow ? shadow : 8'h00;
	wire [31:0] next_rdata = {24'h00_0000, rd_byte};
	wire [1:0] next_rresp = rd_known ? vdc_pkg::RESP_OKAY :
		vdc_pkg::RESP_SLVERR;
	// ready drops after a take and while data waits for the master
	wire next_arready = !rd_take && !s_axi_rvalid_out &&
		!s_axi_arready_out;

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= vdc_pkg::RESP_OKAY;
		end else if (clk_en_in) begin
			s_axi_arready_out <= next_arready;
			if (rd_take) begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= next_rdata;
				s_axi_rresp_out <= next_rresp;
			end else if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end
endmodule // vdc_voice_dac_ctrl

/* core/vdc_pkg.sv */
/*
 * Package for the voice converter data control block: register offsets,
 * field positions and reset values.
 * Assumes a 32-bit AXI4-Lite register bus with one register per word.
 */
package vdc_pkg;
	// ********************************************************
	// register map
	// ********************************************************
	localparam logic [3:0] OFF_CODE_HIGH = 4'h0;
	localparam logic [3:0] OFF_CODE_LOW = 4'h4;
	localparam logic [3:0] OFF_CONTROL = 4'h8;
	localparam logic [3:0] OFF_SHADOW = 4'hC;
	// ********************************************************
	// fields, reset values and response codes
	// ********************************************************
	localparam int ENABLE_BIT = 0;
	localparam logic [7:0] CODE_RESET = 8'h00;
	localparam logic ENABLE_RESET = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* tb/vdc_checker.sv */
/* Port assertions for the converter control; bound to the top module. */
`timescale 1ns/100ps
module vdc_checker (
	input wire logic sys_clk_in, arst_n_in, clk_en_in, s_axi_arvalid_in,
	input wire logic s_axi_arready_out, s_axi_rvalid_out, s_axi_bvalid_out,
	input wire logic dac_start_out, dac_enable_out,
	input wire logic [31:0] s_axi_araddr_in, s_axi_rdata_out,
	input wire logic [15:0] dac_code_out
);
	default clocking @(posedge sys_clk_in iff clk_en_in); endclocking
	default disable iff (!arst_n_in);
	property p_rd(logic [3:0] a, logic [7:0] v);
		$past(s_axi_arvalid_in && s_axi_arready_out &&
			s_axi_araddr_in[3:0] == a) |-> s_axi_rdata_out[7:0] == v;
	endproperty
	a_start_one: assert property (
		dac_start_out |=> !dac_start_out) else $error("long start");
	a_start_resp: assert property (
		dac_start_out |-> s_axi_bvalid_out) else $error("lone start");
	a_code_start: assert property (
		$changed(dac_code_out) |-> dac_start_out) else $error("code moved");
	a_en_resp: assert property (
		$changed(dac_enable_out) |-> $past(s_axi_bvalid_out)) else $error("en");
	a_ctrl_read: assert property (
		p_rd(vdc_pkg::OFF_CONTROL, {7'h00, dac_enable_out})) else $error("ctrl");
	a_low_read: assert property (
		p_rd(vdc_pkg::OFF_CODE_LOW, dac_code_out[7:0])) else $error("low");
	a_high_read: assert property (
		p_rd(vdc_pkg::OFF_CODE_HIGH, dac_code_out[15:8])) else $error("high");
	a_rd_upper: assert property (
		s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0) else $error("upper");
	cover property (dac_start_out);
	cover property (dac_start_out && dac_enable_out);
	cover property ($fell(dac_enable_out));
endmodule // vdc_checker
bind vdc_voice_dac_ctrl vdc_checker i_chk (.*);

/* tb/vdc_analog_model.sv */
/* Converter stage model: latches the code on start while powered. */
`timescale 1ns/100ps
module vdc_analog_model (
	input wire logic clk_in, // system clock
	input wire logic [15:0] code_in, // committed code
	input wire logic start_in, // conversion start
	input wire logic enable_in, // power
	output logic [15:0] level_out // output level
);
	always_ff @(posedge clk_in) begin
		if (!enable_in) begin
			level_out <= 16'h0000;
		end else if (start_in) begin
			level_out <= code_in;
		end
	end
endmodule // vdc_analog_model

/* tb/voice_dac_data_control_tb.sv */
/* Bench: register bus tasks and sequences; checker bound separately. */
`timescale 1ns/100ps
module voice_dac_data_control_tb;
	logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [31:0] awa = 0, wd = 0, ara = 0, rdat, got;
	logic [3:0] ws = 0;
	logic awr, wrd, bv, arr, rv, st, en;
	logic [1:0] br, rr, resp;
	logic [15:0] code, lvl;
	int fails = 0, tests_run = 0, starts = 0;
	always #2 clk = ~clk;
	always @(posedge clk) if (st) starts <= starts + 1;
	vdc_voice_dac_ctrl i_dut (.sys_clk_in(clk), .arst_n_in(rst_n),
		.clk_en_in(1'b1), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
		.s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(br),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ara),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rry), .dac_code_out(code), .dac_start_out(st),
		.dac_enable_out(en));
	vdc_analog_model i_ana (.clk_in(clk), .code_in(code), .start_in(st),
		.enable_in(en), .level_out(lvl));
	task chk(input string n, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d, input logic s);
		@(posedge clk);
		awa <= {28'h0, a};
		wd <= {24'h0, d};
		ws <= {4{s}};
		awv <= 1;
		wv <= 1;
		bry <= 1;
		fork
			begin do @(posedge clk); while (!awr); awv <= 0; end
			begin do @(posedge clk); while (!wrd); wv <= 0; end
		join
		while (!bv) @(posedge clk);
		resp = br;
		bry <= 0;
	endtask
	task rdr(input logic [3:0] a);
		@(posedge clk);
		ara <= {28'h0, a};
		arv <= 1;
		rry <= 1;
		do @(posedge clk); while (!arr);
		arv <= 0;
		do @(posedge clk); while (!rv);
		got = rdat;
		resp = rr;
		rry <= 0;
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1;
		for (int i = 0; i < 3; i++) begin
			rdr(4'(4 * i));
			chk("reset", got, 0);
			chk("rresp", resp, vdc_pkg::RESP_OKAY);
		end
		rdr(4'h1);
		chk("rd slverr", resp, vdc_pkg::RESP_SLVERR);
		chk("rd zero", got, 0);
		$display("reset test done");
		wr(vdc_pkg::OFF_CONTROL, 8'hFF, 1);
		rdr(vdc_pkg::OFF_CONTROL);
		chk("ctrl", got, 1);
		chk("enable", en, 1);
		repeat (8) @(posedge clk);
		wr(vdc_pkg::OFF_CODE_LOW, 8'hA5, 1);
		rdr(vdc_pkg::OFF_CODE_LOW);
		chk("low", got, 0);
		rdr(vdc_pkg::OFF_SHADOW);
		chk("shadow", got, 8'hA5);
		chk("code", code, 0);
		wr(vdc_pkg::OFF_CODE_HIGH, 8'h3C, 1);
		wr(vdc_pkg::OFF_CODE_HIGH, 8'h3C, 1);
		wr(vdc_pkg::OFF_CODE_HIGH, 8'h11, 0);
		chk("okay", resp, vdc_pkg::RESP_OKAY);
		rdr(vdc_pkg::OFF_CODE_LOW);
		chk("low", got, 8'hA5);
		chk("level", lvl, 16'h3CA5);
		chk("starts", starts, 2);
		$display("code test done");
		wr(vdc_pkg::OFF_SHADOW, 8'h00, 1);
		chk("slverr", resp, vdc_pkg::RESP_SLVERR);
		wr(vdc_pkg::OFF_CONTROL, 8'hFE, 1);
		rdr(vdc_pkg::OFF_CONTROL);
		chk("ctrl", got, 0);
		chk("disable", en, 0);
		$display("control test done");
		report_and_stop;
	end
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		report_and_stop;
	end
endmodule // voice_dac_data_control_tb
